// >>> dv/fp_system_model.sv
// system power model standing behind the gated button outputs
// assumes the chipset toggles main power on each accepted power button press
`timescale 1ns/1ps

module fp_system_model
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic pwrBtnOut,
  input  wire logic rstBtnOut,
  input  wire logic sleepBtnOut,
  output logic      sysPowered,
  output int        nResets,
  output int        nSleeps
);
  logic [2:0] prev;

  // power must be defined before the first edge, the block gates on it
  initial sysPowered = 1'b0;

  // only rising edges count: a held button is one request, as on the chipset
  always @(posedge clk)
  begin
    if (srst)
    begin
      sysPowered <= 1'b0;
      nResets <= 0;
      nSleeps <= 0;
      prev <= 3'h0;
    end
    else
    begin
      prev <= {sleepBtnOut, rstBtnOut, pwrBtnOut};
      if (pwrBtnOut && !prev[0])
        sysPowered <= !sysPowered;
      if (rstBtnOut && !prev[1])
        nResets <= nResets + 1;
      if (sleepBtnOut && !prev[2])
        nSleeps <= nSleeps + 1;
    end
  end
endmodule

// >>> dv/front_panel_status_and_lockout_bench.sv
// self-checking bench for the front panel status and lockout block
// assumes fp_system_model behind the buttons and a blink half period of 4 cycles
`timescale 1ns/1ps

module front_panel_status_and_lockout_bench;
  import fp_status_pkg::*;

`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin nFail++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end

  logic        clk, srst, regWr, regRd, intrusion, secureMode, panelLockout;
  logic        pwrBtn, rstBtn, sleepBtn, pwrBtnOut, rstBtnOut, sleepBtnOut;
  logic        ledGreen, ledAmber, irq, sysPowered;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, rd, exp32;
  logic [2:0]  pwrUnitEvt;
  logic [4:0]  wdogEvt;
  logic [7:0]  fq [$];
  logic [7:0]  inv [$];
  int          nFail, nTests, cycles, nResets, nSleeps;

  front_panel_status_and_lockout #(.BLINK_CYC(4)) u_front_panel_status_and_lockout (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .intrusion(intrusion), .secureMode(secureMode),
    .panelLockout(panelLockout), .sysPowered(sysPowered), .pwrBtn(pwrBtn), .rstBtn(rstBtn),
    .sleepBtn(sleepBtn), .pwrUnitEvt(pwrUnitEvt), .wdogEvt(wdogEvt), .pwrBtnOut(pwrBtnOut),
    .rstBtnOut(rstBtnOut), .sleepBtnOut(sleepBtnOut), .ledGreen(ledGreen),
    .ledAmber(ledAmber), .irq(irq));

  fp_system_model u_fp_system_model (
    .clk(clk), .srst(srst), .pwrBtnOut(pwrBtnOut), .rstBtnOut(rstBtnOut),
    .sleepBtnOut(sleepBtnOut), .sysPowered(sysPowered), .nResets(nResets),
    .nSleeps(nSleeps));

  // ------------------------------------------------------------------
  // bus tasks and reference model
  // ------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask

  function automatic led_mode_t ledExp(input logic [7:0] f, input logic intr);
    if (f[FLT_NOTRDY]) return LED_OFF;
    if (|f[3:0]) return LED_AMBER;
    if (f[FLT_NC_THR] || intr) return LED_AMBER_BLK;
    if (|f[6:5]) return LED_GREEN_BLK;
    return LED_GREEN;
  endfunction

  // level code: 0 dark, 1 blinking, 2 solid over a 16 cycle look
  function automatic int lvl(input int n);
    return (n == 16) ? 2 : (n == 0) ? 0 : 1;
  endfunction

  task automatic ledChk(input logic [7:0] f);
    led_mode_t m;
    int        g;
    int        a;
    wr(OFS_FAULT, {24'h0, f});
    m = ledExp(f, intrusion);
    repeat (4) @(posedge clk);
    g = 0;
    a = 0;
    repeat (16)
    begin
      @(posedge clk);
      #1;
      g += (ledGreen === 1'b1);
      a += (ledAmber === 1'b1);
    end
    `CHK("ledGreen", (m == LED_GREEN) ? 2 : (m == LED_GREEN_BLK) ? 1 : 0, lvl(g))
    `CHK("ledAmber", (m == LED_AMBER) ? 2 : (m == LED_AMBER_BLK) ? 1 : 0, lvl(a))
    rdr(OFS_STATUS);
    `CHK("ledMode", m, rd[9:5])
  endtask

  // b: 0 power, 1 reset, 2 sleep
  task automatic press(input int b);
    logic [2:0] e;
    @(posedge clk);
    e[0] = !secureMode && !(panelLockout && !sysPowered);
    e[1] = !secureMode;
    e[2] = 1'b1;
    e = e & (3'b001 << b);
    {sleepBtn, rstBtn, pwrBtn} <= 3'b001 << b;
    repeat (2) @(posedge clk);
    #1;
    `CHK("buttons", e, {sleepBtnOut, rstBtnOut, pwrBtnOut})
    @(posedge clk);
    {sleepBtn, rstBtn, pwrBtn} <= 3'b000;
    repeat (3) @(posedge clk);
  endtask

  task automatic summarize();
    if (nFail == 0 && nTests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // clock, watchdog on the run length
  // ------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      nFail++;
      summarize();
    end
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    {srst, regWr, regRd, regAddr, regWdata} = {1'b1, 42'h0};
    {intrusion, secureMode, panelLockout, pwrBtn, rstBtn, sleepBtn} = 6'h0;
    {pwrUnitEvt, wdogEvt} = 8'h0;
    void'($urandom(4095));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    #1;
    `CHK("outputs", 6'h0, {pwrBtnOut, rstBtnOut, sleepBtnOut, ledGreen, ledAmber, irq})
    rdr(OFS_FAULT);
    `CHK("faultRst", 32'h80, rd)
    fq = '{8'h80, 8'h81, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h30, 8'h20, 8'h40, 8'h00, 8'h11};
    repeat (4) fq.push_back(8'($urandom));
    foreach (fq[i]) ledChk(fq[i]);
    @(posedge clk);
    intrusion <= 1'b1;
    ledChk(8'h40);
    ledChk(8'h00);
    // intrusion events only when enabled: a falling edge while disabled, a rising edge while enabled
    wr(OFS_INTMASK, 32'hF);
    for (int en = 0; en < 2; en++)
    begin
      wr(OFS_CTRL, 32'(en));
      wr(OFS_INTSTAT, 32'hF);
      @(posedge clk);
      intrusion <= ~intrusion;
      repeat (3) @(posedge clk);
      `CHK("irqIntrude", en[0], irq)
      rdr(OFS_INTSTAT);
      `CHK("intrudeEvt", 32'(en), rd)
      rdr(OFS_STATUS);
      `CHK("intrudeLvl", intrusion, rd[2])
    end
    rdr(OFS_EVENT);
    `CHK("intrudeRec", {SNS_INTRUDE_NUM, SNS_PHYS_SEC, 8'h6F, 8'h00}, rd)
    wr(OFS_INTMASK, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("irqMasked", 1'b0, irq)
    wr(OFS_INTMASK, 32'hF);
    wr(OFS_INTSTAT, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("irqCleared", 1'b0, irq)
    // lockout blocks power-up only; secure mode blocks power and reset
    @(posedge clk);
    panelLockout <= 1'b1;
    press(0);
    panelLockout <= 1'b0;
    press(0);
    `CHK("poweredOn", 1'b1, sysPowered)
    panelLockout <= 1'b1;
    for (int s = 1; s >= 0; s--)
    begin
      secureMode <= s[0];
      for (int b = 2; b >= 0; b--) press(b);
      if (s == 1)
      begin
        rdr(OFS_INTSTAT);
        `CHK("violIrq", 32'h2, rd)
        rdr(OFS_EVENT);
        `CHK("violRec", {SNS_PLAT_NUM, SNS_PLAT_SEC, 8'h6F, 8'h00}, rd)
      end
    end
    // secure mode alone must also block a power-up from the button
    {panelLockout, secureMode} <= 2'b01;
    press(0);
    `CHK("modelCount", {32'sd1, 32'sd2, 1'b0}, {nResets, nSleeps, sysPowered})
    // every power unit and watchdog offset
    for (int i = 0; i < 8; i++)
    begin
      wr(OFS_INTSTAT, 32'hF);
      @(posedge clk);
      {wdogEvt, pwrUnitEvt} <= 8'(1 << i);
      @(posedge clk);
      {wdogEvt, pwrUnitEvt} <= 8'h0;
      repeat (2) @(posedge clk);
      if (i < 3)
        exp32 = {SNS_PWR_NUM, SNS_PWR_UNIT, RD_SENS_SPEC, 8'(i)};
      else
        exp32 = {SNS_WDOG_NUM, SNS_WDOG2, RD_SENS_SPEC, 8'(i - 3)};
      rdr(OFS_EVENT);
      `CHK("evtRec", exp32, rd)
      rdr(OFS_INTSTAT);
      `CHK("evtIrq", (i < 3) ? 32'h4 : 32'h8, rd)
    end
    // inventory keeps any byte as written
    wr(OFS_INV_ADR, 32'h10);
    repeat (4)
    begin
      inv.push_back(8'($urandom));
      wr(OFS_INV_DAT, {24'h0, inv[$]});
    end
    wr(8'h24, 32'hFFFF_FFFF);
    wr(OFS_INV_ADR, 32'h10);
    foreach (inv[i])
    begin
      rdr(OFS_INV_DAT);
      `CHK("invData", inv[i], rd[7:0])
    end
    rdr(8'h20);
    `CHK("unmapped", 32'h0, rd)
    summarize();
  end
endmodule

// >>> logic/fp_status_pkg.sv
// package for the front panel status and lockout block
// assumes one 125 MHz clock domain and a plain register port
package fp_status_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ           = 125;
  localparam int BLINK_HALF_MS     = 500;
  localparam int BLINK_HALF_CYC    = BLINK_HALF_MS * 1000 * CLK_MHZ;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FAULT   = 8'h00;
  localparam logic [7:0] OFS_CTRL    = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_INTSTAT = 8'h0C;
  localparam logic [7:0] OFS_INTMASK = 8'h10;
  localparam logic [7:0] OFS_EVENT   = 8'h14;
  localparam logic [7:0] OFS_INV_ADR = 8'h18;
  localparam logic [7:0] OFS_INV_DAT = 8'h1C;

  // ----------------------------------------------------------------
  // fault register fields, written by firmware from sensor scans
  // ----------------------------------------------------------------
  localparam int FLT_CRIT_THR = 0;
  localparam int FLT_PWR_CTL  = 1;
  localparam int FLT_MEM_ECC  = 2;
  localparam int FLT_BUS_ERR  = 3;
  localparam int FLT_NC_THR   = 4;
  localparam int FLT_CPU_DIS  = 5;
  localparam int FLT_MEM_MAP  = 6;
  localparam int FLT_NOTRDY   = 7;
  localparam int CTL_EVT_EN   = 0;

  // ----------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------
  localparam int IRQ_INTRUDE  = 0;
  localparam int IRQ_SECVIOL  = 1;
  localparam int IRQ_PWRUNIT  = 2;
  localparam int IRQ_WDOG     = 3;
  localparam int IRQ_W        = 4;

  // ----------------------------------------------------------------
  // event record codes
  // ----------------------------------------------------------------
  localparam logic [7:0] SNS_INTRUDE_NUM  = 8'h07;
  localparam logic [7:0] SNS_PHYS_SEC     = 8'h05;
  localparam logic [7:0] SNS_PLAT_SEC     = 8'h06;
  localparam logic [7:0] SNS_PLAT_NUM     = 8'h02;
  localparam logic [7:0] SNS_PWR_UNIT     = 8'h09;
  localparam logic [7:0] SNS_PWR_NUM      = 8'h03;
  localparam logic [7:0] SNS_WDOG2        = 8'h23;
  localparam logic [7:0] SNS_WDOG_NUM     = 8'h05;
  localparam logic [7:0] RD_SENS_SPEC     = 8'h6F;
  localparam logic [3:0] OFS_GEN_INTRUDE  = 4'h0;
  localparam logic [3:0] OFS_SECMODE_VIOL = 4'h0;
  localparam int         INV_DEPTH        = 256;

  typedef enum logic [4:0] {
    LED_OFF       = 5'b00001,
    LED_AMBER     = 5'b00010,
    LED_AMBER_BLK = 5'b00100,
    LED_GREEN_BLK = 5'b01000,
    LED_GREEN     = 5'b10000
  } led_mode_t;

endpackage

// >>> logic/front_panel_status_and_lockout.sv
// front panel status led, intrusion watch, button lockout and event reporting
// assumes synchronous debounced inputs and a one-cycle-latency register port
//
// Function
// RULE_01: green solid when ready and fault free, green blink when degraded
// RULE_02: amber solid while any critical fan, voltage or temperature condition
// RULE_03: amber blink on non-critical condition when nothing critical exists
// RULE_04: led dark while the system is not ready
// RULE_05: power control fault counts as critical
// RULE_06: uncorrectable ecc and fatal bus errors count as critical
// RULE_07: non-critical thresholds and chassis intrusion count as non-critical
// RULE_08: disabled processors or mapped-out memory mean degraded
// RULE_09: intrusion level visible; each change raises sensor 07h type 05h event
// RULE_10: secure mode blocks power-down and reset button actions
// RULE_11: sleep button passes through even in secure mode
// RULE_12: power or reset press during secure mode raises violation event
// RULE_13: button power-up blocked by secure mode or lockout input
// RULE_14: inventory store gives raw read and write only
// RULE_15: power unit events reported as type 09h, reading type 6Fh
// RULE_16: watchdog outcomes reported on sensor 05h type 23h, distinct offsets
// RULE_17: led priority: not ready, critical, non-critical, degraded, ready
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps

module front_panel_status_and_lockout
  import fp_status_pkg::*;
#(
  parameter int BLINK_CYC = BLINK_HALF_CYC
)
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  input  wire logic        intrusion,
  input  wire logic        secureMode,
  input  wire logic        panelLockout,
  input  wire logic        sysPowered,
  input  wire logic        pwrBtn,
  input  wire logic        rstBtn,
  input  wire logic        sleepBtn,
  input  wire logic [2:0]  pwrUnitEvt,
  input  wire logic [4:0]  wdogEvt,
  output logic             pwrBtnOut,
  output logic             rstBtnOut,
  output logic             sleepBtnOut,
  output logic             ledGreen,
  output logic             ledAmber,
  output logic             irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]        fault_r;
  logic              evtEn_r;
  logic [IRQ_W-1:0]  intStat_r;
  logic [IRQ_W-1:0]  intMask_r;
  logic [31:0]       evtRec_r;
  logic [7:0]        invAdr_r;
  logic [7:0]        invMem [INV_DEPTH];
  logic              intrPrev_r;
  logic              pwrPrev_r;
  logic              rstPrev_r;
  logic [31:0]       blinkCnt_r;
  logic              blink_r;
  led_mode_t         led_r;
  led_mode_t         led_nxt;
  logic              critical;
  logic              nonCrit;
  logic              degraded;
  logic              intrEdge;
  logic              pwrPress;
  logic              rstPress;
  logic              violation;
  logic [IRQ_W-1:0]  intSet;
  logic [2:0]        pwrIdx;
  logic [2:0]        wdIdx;

  // ----------------------------------------------------------------
  // condition classes
  // ----------------------------------------------------------------
  assign critical = fault_r[FLT_CRIT_THR] | fault_r[FLT_PWR_CTL] // [RULE_02] [RULE_05]
                  | fault_r[FLT_MEM_ECC] | fault_r[FLT_BUS_ERR]; // [RULE_06]
  assign nonCrit  = fault_r[FLT_NC_THR] | intrusion;             // [RULE_07]
  assign degraded = fault_r[FLT_CPU_DIS] | fault_r[FLT_MEM_MAP]; // [RULE_08]

  always_comb
  begin
    if (fault_r[FLT_NOTRDY])
      led_nxt = LED_OFF;                                         // [RULE_04] [RULE_17]
    else if (critical)
      led_nxt = LED_AMBER;                                       // [RULE_02]
    else if (nonCrit)
      led_nxt = LED_AMBER_BLK;                                   // [RULE_03]
    else if (degraded)
      led_nxt = LED_GREEN_BLK;                                   // [RULE_01]
    else
      led_nxt = LED_GREEN;                                       // [RULE_01]
  end

  // ----------------------------------------------------------------
  // blink timebase
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      blinkCnt_r <= 32'h0;
      blink_r    <= 1'b0;
    end
    else if (blinkCnt_r >= 32'(BLINK_CYC - 1))
    begin
      blinkCnt_r <= 32'h0;
      blink_r    <= ~blink_r;
    end
    else
      blinkCnt_r <= blinkCnt_r + 32'h1;
  end

  // ----------------------------------------------------------------
  // led drive
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      led_r    <= LED_OFF;
      ledGreen <= 1'b0;
      ledAmber <= 1'b0;
    end
    else
    begin
      led_r <= led_nxt;
      unique case (led_nxt)
        LED_OFF:       begin ledGreen <= 1'b0;    ledAmber <= 1'b0;    end
        LED_AMBER:     begin ledGreen <= 1'b0;    ledAmber <= 1'b1;    end
        LED_AMBER_BLK: begin ledGreen <= 1'b0;    ledAmber <= blink_r; end
        LED_GREEN_BLK: begin ledGreen <= blink_r; ledAmber <= 1'b0;    end
        LED_GREEN:     begin ledGreen <= 1'b1;    ledAmber <= 1'b0;    end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // buttons and lockout
  // ----------------------------------------------------------------
  assign intrEdge  = intrusion ^ intrPrev_r;
  assign pwrPress  = pwrBtn & ~pwrPrev_r;
  assign rstPress  = rstBtn & ~rstPrev_r;
  assign violation = secureMode & (pwrPress | rstPress);         // [RULE_12]

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      intrPrev_r  <= 1'b0;
      pwrPrev_r   <= 1'b0;
      rstPrev_r   <= 1'b0;
      pwrBtnOut   <= 1'b0;
      rstBtnOut   <= 1'b0;
      sleepBtnOut <= 1'b0;
    end
    else
    begin
      intrPrev_r  <= intrusion;
      pwrPrev_r   <= pwrBtn;
      rstPrev_r   <= rstBtn;
      // powered: secure mode blocks power-down; off: lockout also blocks power-up
      pwrBtnOut   <= pwrBtn & ~secureMode                        // [RULE_10] [RULE_13]
                   & (sysPowered | ~panelLockout);
      rstBtnOut   <= rstBtn & ~secureMode;                       // [RULE_10]
      sleepBtnOut <= sleepBtn;                                   // [RULE_11]
    end
  end

  // ----------------------------------------------------------------
  // event record and interrupt status
  // ----------------------------------------------------------------
  always_comb
  begin
    pwrIdx = 3'h0;
    wdIdx  = 3'h0;
    for (int i = 2; i >= 0; i--)
      if (pwrUnitEvt[i])
        pwrIdx = 3'(i);
    for (int i = 4; i >= 0; i--)
      if (wdogEvt[i])
        wdIdx = 3'(i);
  end

  assign intSet[IRQ_INTRUDE] = evtEn_r & intrEdge;               // [RULE_09]
  assign intSet[IRQ_SECVIOL] = violation;
  assign intSet[IRQ_PWRUNIT] = |pwrUnitEvt;
  assign intSet[IRQ_WDOG]    = |wdogEvt;

  // record: {sensor number, sensor type, reading type, offset}; one event per cycle
  always_ff @(posedge clk)
  begin
    if (srst)
      evtRec_r <= 32'h0;
    else if (intSet[IRQ_INTRUDE])
      evtRec_r <= {SNS_INTRUDE_NUM, SNS_PHYS_SEC, RD_SENS_SPEC,  // [RULE_09]
                   4'h0, OFS_GEN_INTRUDE};
    else if (violation)
      evtRec_r <= {SNS_PLAT_NUM, SNS_PLAT_SEC, RD_SENS_SPEC,     // [RULE_12]
                   4'h0, OFS_SECMODE_VIOL};
    else if (intSet[IRQ_PWRUNIT])
      evtRec_r <= {SNS_PWR_NUM, SNS_PWR_UNIT, RD_SENS_SPEC,      // [RULE_15]
                   5'h0, pwrIdx};
    else if (intSet[IRQ_WDOG])
      evtRec_r <= {SNS_WDOG_NUM, SNS_WDOG2, RD_SENS_SPEC,        // [RULE_16]
                   5'h0, wdIdx};
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      intStat_r <= '0;
    else if (regWr && regAddr == OFS_INTSTAT)
      intStat_r <= (intStat_r & ~regWdata[IRQ_W-1:0]) | intSet;
    else
      intStat_r <= intStat_r | intSet;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |(intStat_r & intMask_r);
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fault_r   <= 8'h80;
      evtEn_r   <= 1'b0;
      intMask_r <= '0;
      invAdr_r  <= 8'h0;
    end
    else if (regWr)
    begin
      unique case (regAddr)
        OFS_FAULT:   fault_r   <= regWdata[7:0];
        OFS_CTRL:    evtEn_r   <= regWdata[CTL_EVT_EN];
        OFS_INTMASK: intMask_r <= regWdata[IRQ_W-1:0];
        OFS_INV_ADR: invAdr_r  <= regWdata[7:0];
        OFS_INV_DAT: invAdr_r  <= invAdr_r + 8'h1;
        default:     ;
      endcase
    end
    else if (regRd && regAddr == OFS_INV_DAT)
      invAdr_r <= invAdr_r + 8'h1;
  end

  // raw byte store; contents are never checked or interpreted
  always_ff @(posedge clk)
  begin
    if (regWr && regAddr == OFS_INV_DAT)
      invMem[invAdr_r] <= regWdata[7:0];                         // [RULE_14]
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      regRdata <= 32'h0;
    else if (regRd)
    begin
      unique case (regAddr)
        OFS_FAULT:   regRdata <= {24'h0, fault_r};
        OFS_CTRL:    regRdata <= {31'h0, evtEn_r};
        OFS_STATUS:  regRdata <= {22'h0, led_r, secureMode, panelLockout, // [RULE_09]
                                  intrusion, 2'h0};
        OFS_INTSTAT: regRdata <= {28'h0, intStat_r};
        OFS_INTMASK: regRdata <= {28'h0, intMask_r};
        OFS_EVENT:   regRdata <= evtRec_r;
        OFS_INV_ADR: regRdata <= {24'h0, invAdr_r};
        OFS_INV_DAT: regRdata <= {24'h0, invMem[invAdr_r]};      // [RULE_14]
        default:     regRdata <= 32'h0;
      endcase
    end
    else
      regRdata <= 32'h0;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_notrdy_dark: assert property (@(posedge clk) disable iff (srst) // [RULE_04]
    fault_r[FLT_NOTRDY] |=> !ledGreen && !ledAmber)
    else $error("led lit while not ready");
  a_crit_amber: assert property (@(posedge clk) disable iff (srst) // [RULE_02]
    (!fault_r[FLT_NOTRDY] && critical) |=> ledAmber && !ledGreen)
    else $error("critical without solid amber");
  a_pwrfault_crit: assert property (@(posedge clk) disable iff (srst) // [RULE_05]
    (fault_r == 8'h02) |=> ledAmber)
    else $error("power fault not critical");
  a_ecc_crit: assert property (@(posedge clk) disable iff (srst) // [RULE_06]
    (fault_r == 8'h04 || fault_r == 8'h08) |=> led_r == LED_AMBER)
    else $error("ecc or bus error not critical");
  a_nc_blink: assert property (@(posedge clk) disable iff (srst) // [RULE_03] [RULE_07]
    (fault_r == 8'h00 && intrusion) |=> !ledGreen)
    else $error("non-critical shows green");
  a_degr_blink: assert property (@(posedge clk) disable iff (srst) // [RULE_08] [RULE_01]
    (fault_r == 8'h20 && !intrusion) |=> !ledAmber)
    else $error("degraded shows amber");
  a_ready_green: assert property (@(posedge clk) disable iff (srst) // [RULE_01] [RULE_17]
    (fault_r == 8'h00 && !intrusion) |=> ledGreen)
    else $error("ready not solid green");
  a_secure_block: assert property (@(posedge clk) disable iff (srst) // [RULE_10]
    secureMode |=> !pwrBtnOut && !rstBtnOut)
    else $error("button passed in secure mode");
  a_sleep_pass: assert property (@(posedge clk) disable iff (srst) // [RULE_11]
    sleepBtn |=> sleepBtnOut)
    else $error("sleep request dropped");
  a_lock_powerup: assert property (@(posedge clk) disable iff (srst) // [RULE_13]
    (panelLockout && !sysPowered) |=> !pwrBtnOut)
    else $error("power-up not locked out");
  // antecedent taken from the pins so a broken press detector cannot hide
  a_viol_event: assert property (@(posedge clk) disable iff (srst) // [RULE_12]
    (secureMode && ($rose(pwrBtn) || $rose(rstBtn))) |=> intStat_r[IRQ_SECVIOL])
    else $error("violation not flagged");
  a_intr_event: assert property (@(posedge clk) disable iff (srst) // [RULE_09]
    (evtEn_r && intrEdge) |=> evtRec_r[31:16] == 16'h0705)
    else $error("intrusion event record wrong");

  // a pulse is flagged next cycle and reaches irq one cycle after that
  sequence s_pwr_flagged;
    intStat_r[IRQ_PWRUNIT] ##1 irq;
  endsequence
  sequence s_wdog_flagged;
    intStat_r[IRQ_WDOG] ##1 irq;
  endsequence

  a_pwr_irq: assert property (@(posedge clk) disable iff (srst) // [RULE_15]
    ((|pwrUnitEvt) && intMask_r[IRQ_PWRUNIT] && !(regWr && regAddr == OFS_INTMASK))
    |=> s_pwr_flagged)
    else $error("power unit event not flagged");
  a_wdog_irq: assert property (@(posedge clk) disable iff (srst) // [RULE_16]
    ((|wdogEvt) && intMask_r[IRQ_WDOG] && !(regWr && regAddr == OFS_INTMASK))
    |=> s_wdog_flagged)
    else $error("watchdog event not flagged");
  a_pwr_record: assert property (@(posedge clk) disable iff (srst) // [RULE_15]
    ((|pwrUnitEvt) && !intSet[IRQ_INTRUDE] && !violation)
    |=> evtRec_r[31:8] == {SNS_PWR_NUM, SNS_PWR_UNIT, RD_SENS_SPEC})
    else $error("power unit record wrong");
  a_wdog_record: assert property (@(posedge clk) disable iff (srst) // [RULE_16]
    ($onehot(wdogEvt) && !(|pwrUnitEvt) && !intSet[IRQ_INTRUDE] && !violation)
    |=> evtRec_r[31:8] == {SNS_WDOG_NUM, SNS_WDOG2, RD_SENS_SPEC}
        && evtRec_r[7:3] == 5'h00 && $past(wdogEvt) == (5'h01 << evtRec_r[2:0]))
    else $error("watchdog record wrong");

endmodule
